/* rtl/ssc_regs.svh */
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
// ==================================================
// register port map
`define SSC_ADDR_W      2
`define SSC_A_CTRL      2'h0
`define SSC_A_STAT      2'h1
`define SSC_A_TXB       2'h2
`define SSC_A_RXB       2'h3
`define SSC_CTRL_RST    8'h00
// control bits
`define SSC_C_CONT      0
`define SSC_C_PHASE     1
`define SSC_C_MASTER    2
`define SSC_C_SRST_N    3
`define SSC_C_IRQ_EN    4
`define SSC_C_DOUT_EN   5
`define SSC_C_DIN_EN    6
`define SSC_C_CLK_EN    7
// status bits
`define SSC_S_TXFULL    0
`define SSC_S_RXFULL    1
`define SSC_S_TBSY      2
`define SSC_S_RBSY      3
`define SSC_S_ORE       4
`define SSC_S_ERE       5
`define SSC_S_IRQ       6
// ==================================================
// timing; waits in half transfer clocks
`define SSC_CNT_W       8
`define SSC_WAIT_HALVES 4'h7
`define SSC_TAIL_HALVES 4'h2
`define SSC_CHAIN_LIMIT 4'h7
`define SSC_BYTE_BITS   4'h8
`define SSC_SCK_IDLE    1'b1
`endif

/* rtl/ssc_pkg.sv */
package ssc_pkg;
`include "ssc_regs.svh"
	// sequencer phases
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT, ST_TAIL} seq_t;

	// whole channel state
	typedef struct packed {
		seq_t                   st;
		logic [7:0]             ctrl;
		logic [7:0]             txbuf;
		logic [7:0]             shreg;
		logic [7:0]             rxbuf;
		logic [7:0]             rdata;
		logic [`SSC_CNT_W-1:0]  cnt;
		logic [3:0]             halves;
		logic [3:0]             bits;
		logic                   txfull;
		logic                   rxfull;
		logic                   tbsy;
		logic                   rbsy;
		logic                   ore;
		logic                   ere;
		logic                   irq_req;
		logic                   irq;
		logic                   late;
		logic                   sck;
		logic                   sck_prev;
		logic                   sdo;
		logic                   sck_oe_n;
		logic                   sdo_oe_n;
		logic                   ready;
	} chan_t;
endpackage : ssc_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	// asynchronous levels in, synchronised out
	input  wire logic [W-1:0]  pin_in,
	output logic      [W-1:0]  pin_out
);
	logic [W-1:0] meta_q;

	if (W < 1)
	begin : g_bad_w
		$error("pin_sync width must be at least one");
	end

	// two stages; first stage feeds only the second
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_q  <= '0;
			pin_out <= '0;
		end
		else if (ce)
		begin
			meta_q  <= pin_in;
			pin_out <= meta_q;
		end
	end
endmodule : pin_sync

/* rtl/sync_serial_channel.sv */
`timescale 1ns/100ps
`include "ssc_regs.svh"
module sync_serial_channel
	import ssc_pkg::*;
#(
	parameter int HALF_CYC = 8,
	parameter bit LOW_PAIR = 1'b1
) (
	// clock, reset, enable
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic                    ce,
	// register port
	input  wire logic [`SSC_ADDR_W-1:0]  reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	// serial pins
	input  wire logic                    sck_i,
	output logic                         sck_o,
	output logic                         sck_oe_n,
	output logic                         sdo_o,
	output logic                         sdo_oe_n,
	input  wire logic                    sdi_i,
	// system side
	output logic                         slave_ready,
	output logic                         transfer_done_irq
);
	import ssc_pkg::*;

	// ==================================================
	// parameters and checks
	localparam logic [`SSC_CNT_W-1:0] CNT_LAST = `SSC_CNT_W'(HALF_CYC - 1);
	localparam int WAIT_MAX = 32'(`SSC_WAIT_HALVES) * HALF_CYC + 3;
	localparam int GAP_MAX  = 32'(`SSC_WAIT_HALVES + `SSC_TAIL_HALVES) * HALF_CYC + 4;

	if (HALF_CYC < 2 || HALF_CYC >= (1 << `SSC_CNT_W))
	begin : g_bad_half
		$error("HALF_CYC out of range for the half-period counter");
	end

	chan_t q;
	chan_t d;
	logic  s_sck;
	logic  s_sdi;
	logic  half_tick;
	logic  rise;
	logic  fall;
	logic  done;
	logic  load;
	logic  chain;

	// ==================================================
	// pin synchronisers
	pin_sync #(.W(2)) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.ce      (ce),
		.pin_in  ({sck_i, sdi_i}),
		.pin_out ({s_sck, s_sdi})
	);

	// ==================================================
	// next-state logic
	always_comb
	begin
		d         = q;
		half_tick = 1'b0;
		rise      = 1'b0;
		fall      = 1'b0;
		done      = 1'b0;
		load      = 1'b0;
		chain     = 1'b0;
		d.rdata   = 8'h00;
		d.sck_prev = s_sck;

		// register writes; decode by address chain
		if (reg_wr)
		begin
			if (reg_addr == `SSC_A_CTRL)
			begin
				d.ctrl = reg_wdata;
			end
			else if (reg_addr == `SSC_A_STAT)
			begin
				if (!reg_wdata[`SSC_S_IRQ])
					d.irq_req = 1'b0;
				// upper pair clears overrun by software
				if (!LOW_PAIR && !reg_wdata[`SSC_S_ORE])
					d.ore = 1'b0;
			end
			else if (reg_addr == `SSC_A_TXB && q.ctrl[`SSC_C_SRST_N])
			begin
				d.txbuf  = reg_wdata;
				d.txfull = 1'b1;
				if (LOW_PAIR)
				begin
					d.tbsy = q.tbsy | q.ctrl[`SSC_C_DOUT_EN];
					d.rbsy = q.rbsy | q.ctrl[`SSC_C_DIN_EN];
				end
				else
					d.tbsy = 1'b1;
				if (q.st == ST_SHIFT && q.bits >= `SSC_CHAIN_LIMIT)
					d.late = 1'b1;
				if (q.st == ST_IDLE)
				begin
					d.st     = ST_WAIT;
					d.halves = 4'h0;
					d.cnt    = '0;
				end
			end
		end

		// register reads; data stand one cycle later
		if (reg_rd)
		begin
			if (reg_addr == `SSC_A_CTRL)
				d.rdata = q.ctrl;
			else if (reg_addr == `SSC_A_STAT)
			begin
				d.rdata[`SSC_S_TXFULL] = q.txfull;
				d.rdata[`SSC_S_RXFULL] = q.rxfull;
				d.rdata[`SSC_S_TBSY]   = q.tbsy;
				d.rdata[`SSC_S_RBSY]   = q.rbsy;
				d.rdata[`SSC_S_ORE]    = q.ore;
				d.rdata[`SSC_S_ERE]    = q.ere;
				d.rdata[`SSC_S_IRQ]    = q.irq_req;
			end
			else if (reg_addr == `SSC_A_TXB)
				d.rdata = q.txbuf;
			else
			begin
				// reading the receive buffer empties it
				d.rdata  = q.rxbuf;
				d.rxfull = 1'b0;
			end
		end

		// half-period timebase, also times slave waits
		if (q.st != ST_IDLE)
		begin
			if (q.cnt == CNT_LAST)
			begin
				d.cnt     = '0;
				half_tick = 1'b1;
			end
			else
				d.cnt = q.cnt + 1'b1;
		end

		case (q.st)
			ST_IDLE:
			begin
				d.sck = `SSC_SCK_IDLE;
			end
			ST_WAIT:
			begin
				if (half_tick)
				begin
					d.halves = q.halves + 1'b1;
					if (q.halves == `SSC_WAIT_HALVES - 1'b1)
						load = 1'b1;
				end
			end
			ST_SHIFT:
			begin
				if (q.ctrl[`SSC_C_MASTER])
				begin
					if (half_tick)
					begin
						d.sck = ~q.sck;
						fall  = q.sck;
						rise  = ~q.sck;
					end
				end
				else
				begin
					fall = q.sck_prev & ~s_sck;
					rise = ~q.sck_prev & s_sck;
				end
				// shift out on the falling edge, sample on rising
				if (fall)
					d.sdo = q.shreg[7];
				if (rise)
				begin
					d.shreg = {q.shreg[6:0], s_sdi};
					d.bits  = q.bits + 1'b1;
					if (q.bits == `SSC_BYTE_BITS - 1'b1)
						done = 1'b1;
				end
			end
			ST_TAIL:
			begin
				d.sck = `SSC_SCK_IDLE;
				if (half_tick)
				begin
					d.halves = q.halves + 1'b1;
					if (q.halves == `SSC_TAIL_HALVES - 1'b1)
					begin
						d.st     = q.txfull ? ST_WAIT : ST_IDLE;
						d.halves = 4'h0;
					end
				end
			end
			default:
			begin
				d.st = ST_IDLE;
			end
		endcase

		// byte completion; set beats a same-cycle read or status-write clear, but not a serial soft reset
		if (done)
		begin
			d.rxbuf  = d.shreg;
			d.rxfull = 1'b1;
			if (q.rxfull)
			begin
				d.ore = 1'b1;
				d.ere = LOW_PAIR;
			end
			else if (LOW_PAIR)
			begin
				d.ore = 1'b0;
				d.ere = 1'b0;
			end
			d.irq_req = 1'b1;
			chain = q.ctrl[`SSC_C_CONT] & q.txfull & ~d.late;
			if (chain)
				load = 1'b1;
			else
			begin
				d.st     = ST_TAIL;
				d.halves = 4'h0;
				d.cnt    = '0;
				// busy flags drop
				// a full transmit buffer, pending or written with completion, keeps them set
				if (!d.txfull)
				begin
					d.tbsy = 1'b0;
					d.rbsy = 1'b0;
				end
			end
		end

		if (load)
		begin
			d.st     = ST_SHIFT;
			d.shreg  = q.txbuf;
			d.sdo    = q.txbuf[7];
			d.txfull = 1'b0;
			d.late   = 1'b0;
			d.bits   = 4'h0;
		end

		// serial soft reset holds the sequencer and flags
		if (!d.ctrl[`SSC_C_SRST_N])
		begin
			d.st      = ST_IDLE;
			d.txfull  = 1'b0;
			d.rxfull  = 1'b0;
			d.tbsy    = 1'b0;
			d.rbsy    = 1'b0;
			d.ore     = 1'b0;
			d.ere     = 1'b0;
			d.irq_req = 1'b0;
			d.late    = 1'b0;
			d.bits    = 4'h0;
			d.sck     = `SSC_SCK_IDLE;
		end

		// pin drivers and system outputs
		d.sck_oe_n = ~(d.ctrl[`SSC_C_MASTER] & d.ctrl[`SSC_C_CLK_EN]);
		d.sdo_oe_n = ~d.ctrl[`SSC_C_DOUT_EN];
		d.ready    = ~d.ctrl[`SSC_C_MASTER] & (d.st == ST_SHIFT);
		d.irq      = d.irq_req & d.ctrl[`SSC_C_IRQ_EN];
	end

	// ==================================================
	// state register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q          <= '0;
			q.st       <= ST_IDLE;
			q.ctrl     <= `SSC_CTRL_RST;
			q.sck      <= `SSC_SCK_IDLE;
			q.sck_oe_n <= 1'b1;
			q.sdo_oe_n <= 1'b1;
		end
		else if (ce)
			q <= d;
	end

	assign reg_rdata         = q.rdata;
	assign sck_o             = q.sck;
	assign sck_oe_n          = q.sck_oe_n;
	assign sdo_o             = q.sdo;
	assign sdo_oe_n          = q.sdo_oe_n;
	assign slave_ready       = q.ready;
	assign transfer_done_irq = q.irq;

	// ==================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst || !ce);

	AST_TXFULL_SET: assert property (
		(reg_wr && reg_addr == `SSC_A_TXB && q.ctrl[`SSC_C_SRST_N] && d.ctrl[`SSC_C_SRST_N]
		 && !load) |=> q.txfull)
		else $error("buffer full not set by transmit write");

	AST_WAIT_LEN: assert property (
		($rose(q.st == ST_WAIT) && q.ctrl[`SSC_C_SRST_N])
		|-> ##[1:WAIT_MAX] (q.st != ST_WAIT))
		else $error("start wait longer than 3.5T");

	AST_LATE_GAP: assert property (
		(reg_wr && reg_addr == `SSC_A_TXB && q.st == ST_IDLE && d.ctrl[`SSC_C_SRST_N])
		|-> ##[1:GAP_MAX] (q.st == ST_SHIFT || !q.ctrl[`SSC_C_SRST_N]))
		else $error("transfer did not start within 4.5T of write");

	AST_SINGLE_GAP: assert property (
		(done && !q.ctrl[`SSC_C_CONT] && q.txfull && d.ctrl[`SSC_C_SRST_N])
		|=> (q.st == ST_TAIL) ##[1:GAP_MAX] (q.st == ST_SHIFT || !q.ctrl[`SSC_C_SRST_N]))
		else $error("single-byte gap missing or too long");

	AST_CHAIN: assert property (
		(done && q.ctrl[`SSC_C_CONT] && q.txfull && !q.late && !reg_wr && d.ctrl[`SSC_C_SRST_N])
		|=> (q.st == ST_SHIFT && q.bits == 4'h0 && !q.txfull))
		else $error("consecutive byte not chained without gap");

	AST_LATE_MASK: assert property (
		(done && q.late && !q.ctrl[`SSC_C_MASTER] && d.ctrl[`SSC_C_SRST_N])
		|=> (q.st == ST_TAIL && !q.ready) [*2])
		else $error("late slave load did not mask the clock");

	AST_MASTER_STOP: assert property (
		(q.st == ST_IDLE && $past(q.st) == ST_IDLE) |-> (q.sck == `SSC_SCK_IDLE))
		else $error("master clock moved while idle");

	AST_SLAVE_MASK: assert property (
		(q.st == ST_IDLE && !q.ctrl[`SSC_C_MASTER] && !reg_wr)
		|=> ($stable(q.shreg) && $stable(q.bits)))
		else $error("slave shifted while clock masked");

	AST_BUSY_DROP: assert property (
		(done && !q.txfull && !reg_wr)
		|=> (!q.tbsy && !q.rbsy && q.irq_req && q.rxfull))
		else $error("busy flags not cleared at completion");

	AST_OVERRUN: assert property (
		(done && q.rxfull && !reg_rd && d.ctrl[`SSC_C_SRST_N])
		|=> (q.ore && q.ere == LOW_PAIR))
		else $error("overrun flags wrong after overrun");

	AST_IRQ_OUT: assert property (
		(done && q.ctrl[`SSC_C_IRQ_EN] && !reg_wr && d.ctrl[`SSC_C_SRST_N])
		|=> transfer_done_irq ##1 (transfer_done_irq || $past(reg_wr)))
		else $error("completion interrupt not raised");
endmodule : sync_serial_channel

/* bench/serial_peer.sv */
`timescale 1ns/100ps
// ==================================================
// far-side serial peer, master or slave as the device needs
module serial_peer (
	// system clock, used to find device clock edges and to time clock-high runs
	input  wire logic  clk_sys,
	// device pins
	input  wire logic  sck_o,
	input  wire logic  sdo_o,
	// peer pins
	output logic       sck_i,
	output logic       sdi_i
);
	logic [7:0]  txb = 8'h3c;
	logic [7:0]  rxb = 8'h00;
	logic        sck_q = 1'b1;
	int          k = 0;
	int          run = 0;
	int          gap = 0;

	// clock idles high; data line parked on a changing level
	initial
	begin
		sck_i = 1'b1;
		sdi_i = 1'b0;
	end

	// slave of a master device: answer on its fall, sample on its rise
	always @(posedge clk_sys)
	begin
		sck_q <= sck_o;
		run <= sck_o ? run + 1 : 0;
		if (sck_q && !sck_o)
		begin
			sdi_i <= txb[7 - k];
			if (run > gap)
				gap <= run;
		end
		if (!sck_q && sck_o)
		begin
			rxb <= {rxb[6:0], sdo_o};
			k <= (k == 7) ? 0 : k + 1;
			// released line must not keep the last bit
			if (k == 7)
				sdi_i <= ~sdi_i;
		end
	end

	// master of a slave device: one byte at a 64 ns period, msb first
	task automatic frame;
		#1.3;
		for (int i = 7; i >= 0; i--)
		begin
			sck_i = 1'b0;
			sdi_i = txb[i];
			#32;
			sck_i = 1'b1;
			rxb = {rxb[6:0], sdo_o};
			#32;
		end
		sdi_i = ~sdi_i;
	endtask : frame
endmodule : serial_peer

/* bench/tb.sv */
`timescale 1ns/100ps
`include "ssc_regs.svh"
module tb;
	import ssc_pkg::*;
	localparam int HALF = 8;
	// ==================================================
	// signals
	logic                    clk_sys;
	logic                    sys_rst;
	logic                    ce;
	logic [`SSC_ADDR_W-1:0]  reg_addr;
	logic [7:0]              reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [7:0]              reg_rdata;
	logic [7:0]              rd_val;
	logic                    sck_i;
	logic                    sdi_i;
	logic                    sck_o;
	logic                    sck_oe_n;
	logic                    sdo_o;
	logic                    sdo_oe_n;
	logic                    slave_ready;
	logic                    transfer_done_irq;
	int                      miscompares = 0;
	int                      n_tests = 0;
	int                      n;

	sync_serial_channel #(.HALF_CYC(HALF), .LOW_PAIR(1'b1)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sck_i(sck_i), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
		.sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sdi_i(sdi_i),
		.slave_ready(slave_ready), .transfer_done_irq(transfer_done_irq)
	);

	serial_peer peer (
		.clk_sys(clk_sys), .sck_o(sck_o), .sdo_o(sdo_o),
		.sck_i(sck_i), .sdi_i(sdi_i)
	);

	// 250 MHz system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ==================================================
	// register port tasks
	task automatic wr(input logic [`SSC_ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [`SSC_ADDR_W-1:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", w, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic rc(input string w, input logic [`SSC_ADDR_W-1:0] a, input logic [7:0] e);
		rd(a);
		chk(w, e, rd_val);
	endtask : rc

	// bounded wait: a hang counts as a mismatch and ends the run
	task automatic guard;
		n++;
		if (n > 600)
		begin
			miscompares++;
			complete_run();
		end
	endtask : guard

	// bounded wait for the slave clock gate to open
	task automatic wait_ready;
		n = 0;
		while (slave_ready !== 1'b1)
		begin
			@(posedge clk_sys);
			#1 guard();
		end
	endtask : wait_ready

	task automatic wait_stat(input int b, input logic v);
		n = 0;
		rd(`SSC_A_STAT);
		while (rd_val[b] !== v)
		begin
			guard();
			rd(`SSC_A_STAT);
		end
	endtask : wait_stat

	// two bytes, second written early in the first; gap seen by the peer
	task automatic two_bytes(input logic [7:0] a, input logic [7:0] b);
		wr(`SSC_A_TXB, a);
		wait_stat(`SSC_S_TXFULL, 1'b0);
		repeat (3 * HALF) @(posedge clk_sys);
		#1 peer.gap = 0;
		wr(`SSC_A_TXB, b);
		wait_stat(`SSC_S_TBSY, 1'b0);
	endtask : two_bytes

	// ==================================================
	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		reg_addr = '0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rc("ctrl", `SSC_A_CTRL, `SSC_CTRL_RST);
		rc("stat", `SSC_A_STAT, 8'h00);
		chk("idle pins", 8'h07, {5'h0, sck_o, sck_oe_n, sdo_oe_n});
		wr(`SSC_A_TXB, 8'h99);
		rc("stat srst", `SSC_A_STAT, 8'h00);
		$display("test reset done");

		// master, single byte; modes set under serial reset, then released
		wr(`SSC_A_CTRL, 8'hf4);
		wr(`SSC_A_CTRL, 8'hfc);
		wr(`SSC_A_TXB, 8'ha5);
		rc("stat start", `SSC_A_STAT, 8'h0d);
		chk("sck wait", 8'h01, {7'h0, sck_o});
		chk("master oe", 8'h00, {6'h0, sck_oe_n, sdo_oe_n});
		wait_stat(`SSC_S_RXFULL, 1'b1);
		rc("stat done", `SSC_A_STAT, 8'h42);
		chk("irq pin", 8'h01, {7'h0, transfer_done_irq});
		chk("peer rx", 8'ha5, peer.rxb);
		rc("rxbuf", `SSC_A_RXB, 8'h3c);
		wr(`SSC_A_STAT, 8'h00);
		rc("stat clr", `SSC_A_STAT, 8'h00);
		$display("test master byte done");

		// single mode gap, overrun on unread byte
		two_bytes(8'h11, 8'h22);
		chk("gap single", 8'h01, {7'h0, peer.gap >= 9 * HALF && peer.gap <= 10 * HALF + 3});
		rc("stat ovr", `SSC_A_STAT, 8'h72);
		rc("rxbuf ovr", `SSC_A_RXB, 8'h3c);
		$display("test single gap done");

		// continuous mode chains without a gap
		wr(`SSC_A_CTRL, 8'hfd);
		two_bytes(8'h33, 8'h44);
		chk("gap cont", 8'h01, {7'h0, peer.gap <= HALF + 3});
		chk("peer rx cont", 8'h44, peer.rxb);
		rc("stat cont", `SSC_A_STAT, 8'h72);
		rc("rxbuf cont", `SSC_A_RXB, 8'h3c);
		wr(`SSC_A_STAT, 8'h00);
		$display("test continuous done");

		// slave: clock masked while idle, then a real byte
		wr(`SSC_A_CTRL, 8'hf8);
		peer.frame();
		rc("stat masked", `SSC_A_STAT, 8'h30);
		chk("slave oe", 8'h01, {7'h0, sck_oe_n});
		wr(`SSC_A_TXB, 8'h5a);
		wait_ready();
		chk("slave wait", 8'h01, {7'h0, n >= 7 * HALF - 2});
		peer.frame();
		wait_stat(`SSC_S_RXFULL, 1'b1);
		rc("stat slave", `SSC_A_STAT, 8'h42);
		chk("wake irq", 8'h01, {7'h0, transfer_done_irq});
		rc("rxbuf slave", `SSC_A_RXB, 8'h3c);
		chk("peer rx slave", 8'h5a, peer.rxb);
		$display("test slave done");

		// slave continuous, next byte written after the seventh bit
		wr(`SSC_A_CTRL, 8'hf9);
		wr(`SSC_A_TXB, 8'h66);
		wait_ready();
		fork
			peer.frame();
			begin
				repeat (110) @(posedge clk_sys);
				wr(`SSC_A_TXB, 8'h77);
			end
		join
		chk("late gate", 8'h00, {7'h0, slave_ready});
		rc("stat late", `SSC_A_STAT, 8'h4f);
		chk("peer rx late", 8'h66, peer.rxb);
		wait_ready();
		peer.frame();
		wait_stat(`SSC_S_TBSY, 1'b0);
		chk("peer rx next", 8'h77, peer.rxb);
		rc("stat next", `SSC_A_STAT, 8'h72);
		$display("test late slave done");

		// clock enable low freezes the registers
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(`SSC_A_CTRL, 8'h00);
		@(posedge clk_sys);
		ce <= 1'b1;
		rc("ctrl frozen", `SSC_A_CTRL, 8'hf9);
		$display("test clock enable done");
		complete_run();
	end
endmodule : tb
